// ### decode_consts.vh
// constants for the push, rotate-through-carry and repeated-string decoder
`ifndef DECODE_CONSTS_VH
`define DECODE_CONSTS_VH
`define OPC_ESCAPE        8'h0f
`define OPC_REPEAT        8'hf3
`define OPC_GROUP_FF      8'hff
`define OPC_PUSH_ALL      8'h60
`define OPC_PUSH_FLAGS    8'h9c
`define OPC_READ_MODEL_SPECIFIC_REGISTER_2ND     8'h32
`define OPC_READ_TIMESTAMP_COUNTER_2ND     8'h31
`define REG_PUSH          3'b110
`define REG_RCL           3'b010
`define REG_RCR           3'b011
`define CLK_PUSH_ALL      8'h0b
`define CLK_PUSH_FLAGS    8'h02
`define CLK_ONE           8'h01
`define CLK_RCL_ONE       8'h03
`define CLK_RCR_ONE       8'h04
`define CLK_ROT_MULTI     8'h08
`define CLK_INS_REAL      8'h11
`define CLK_INS_PROT      8'h20
`define CLK_OUTPUT_STRING_REAL     8'h18
`define CLK_OUTPUT_STRING_PROT     8'h27
`define CLK_LOAD_STRING          8'h09
`define CLK_MOVE_STRING          8'h0c
`define CLK_STORE_STRING          8'h09
`define CLK_ITER_IO       8'h04
`define CLK_ITER_MEM      8'h02
`define CLS_NONE          5'h00
`define CLS_PUSH_RM       5'h01
`define CLS_PUSH_REG      5'h02
`define CLS_PUSH_SEG2     5'h03
`define CLS_PUSH_SEG3     5'h04
`define CLS_PUSH_IMM      5'h05
`define CLS_PUSH_ALL      5'h06
`define CLS_PUSH_FLAGS    5'h07
`define CLS_RCL           5'h08
`define CLS_RCR           5'h09
`define CLS_READ_MODEL_SPECIFIC_REGISTER         5'h0a
`define CLS_READ_TIMESTAMP_COUNTER         5'h0b
`define CLS_REP_INS       5'h0c
`define CLS_REP_LOAD_STRING      5'h0d
`define CLS_REP_MOVE_STRING      5'h0e
`define CLS_REP_OUTPUT_STRING      5'h0f
`define CLS_REP_STORE_STRING      5'h10
`endif

// ### iteration_counter.v
// repeat-count down-counter for repeated string operations
module iteration_counter #(
    parameter WIDTH = 32
) (
    input  wire             clock,
    input  wire             nrst,
    input  wire             load,
    input  wire [WIDTH-1:0] loadValue,
    input  wire             step,
    output reg  [WIDTH-1:0] count,
    output wire             zero
);
    assign zero = (count == {WIDTH{1'b0}});

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= {WIDTH{1'b0}};
        end else if (load) begin
            count <= loadValue;
        end else if (step && !zero) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule // iteration_counter

// ### instr_decoder.v
// decoder and clock-count sequencer for push, rotate-through-carry and repeated strings
`include "decode_consts.vh"
module instr_decoder #(
    parameter COUNT_WIDTH = 32
) (
    input  wire                   clock,
    input  wire                   nrst,
    input  wire                   byteValid,
    input  wire [7:0]             byteIn,
    input  wire                   protectedMode,
    input  wire                   operandSize32,
    input  wire [COUNT_WIDTH-1:0] countRegister,
    output wire                   byteReady,
    output reg                    instrValid,
    output reg  [4:0]             instrClass,
    output reg  [2:0]             regField,
    output reg  [1:0]             operandWidth,
    output reg                    signExtend,
    output reg                    busy,
    output reg                    done,
    output reg                    iterationStep,
    output reg                    writesOverflowCarry,
    output wire [COUNT_WIDTH-1:0] countRemaining
);
    // ****************************************
    // byte sequencing
    // ****************************************
    localparam S_FIRST  = 3'd0;
    localparam S_ESC    = 3'd1;
    localparam S_REP    = 3'd2;
    localparam S_MODRM  = 3'd3;
    localparam S_SETUP  = 3'd4;
    localparam S_ITER   = 3'd5;

    reg  [2:0] state;
    reg  [2:0] next_state;
    reg  [7:0] firstByte;
    reg  [7:0] cycleCount;
    reg  [7:0] iterCycles;
    reg  [7:0] iterCount;
    reg        isRepeat;
    wire       cntZero;

    // width bit picks byte, else word or doubleword by operand size
    function [1:0] widthOf;
        input w;
        input size32;
        begin
            widthOf = !w ? 2'd0 : (size32 ? 2'd2 : 2'd1);
        end
    endfunction

    assign byteReady = (state == S_FIRST) || (state == S_ESC)
                    || (state == S_REP) || (state == S_MODRM);
    wire take = byteValid && byteReady;

    // rotate forms: D0/D1 count one, D2/D3 count register, C0/C1 immediate
    wire rotByOne = (firstByte[7:1] == 7'b1101000);
    wire rotGroup = (firstByte[7:2] == 6'b110100) || (firstByte[7:1] == 7'b1100000);

    // ****************************************
    // main decode
    // ****************************************
    reg [4:0] dClass;
    reg [7:0] dClocks;
    reg       dDone;
    reg [7:0] dIter;
    reg       dOvCf;

    always @* begin
        dClass   = `CLS_NONE;
        dClocks  = `CLK_ONE;
        dDone    = 1'b0;
        dIter    = 8'h00;
        dOvCf    = 1'b0;
        next_state = state;
        case (state)
            S_FIRST: begin
                if (take) begin
                    if (byteIn == `OPC_ESCAPE) begin
                        next_state = S_ESC;
                    end else if (byteIn == `OPC_REPEAT) begin
                        next_state = S_REP;
                    end else if (byteIn == `OPC_GROUP_FF || byteIn[7:2] == 6'b110100
                                 || byteIn[7:1] == 7'b1100000) begin
                        next_state = S_MODRM;
                    end else if (byteIn[7:3] == 5'b01010) begin
                        dClass = `CLS_PUSH_REG;
                        dDone  = 1'b1;
                    end else if ({byteIn[7:2], byteIn[0]} == 7'b0110100) begin
                        dClass = `CLS_PUSH_IMM;
                        dDone  = 1'b1;
                    end else if (byteIn[7:5] == 3'b000 && byteIn[2:0] == 3'b110) begin
                        dClass = `CLS_PUSH_SEG2;
                        dDone  = 1'b1;
                    end else if (byteIn == `OPC_PUSH_ALL) begin
                        dClass  = `CLS_PUSH_ALL;
                        dClocks = `CLK_PUSH_ALL;
                        dDone   = 1'b1;
                    end else if (byteIn == `OPC_PUSH_FLAGS) begin
                        dClass  = `CLS_PUSH_FLAGS;
                        dClocks = `CLK_PUSH_FLAGS;
                        dDone   = 1'b1;
                    end else begin
                        // unknown opcodes still report, with class none
                        dDone   = 1'b1;
                    end
                end
            end
            S_ESC: begin
                if (take) begin
                    next_state = S_FIRST;
                    dDone = 1'b1;
                    if (byteIn[7:6] == 2'b10 && byteIn[2:0] == 3'b000) begin
                        dClass = `CLS_PUSH_SEG3;
                    end else if (byteIn == `OPC_READ_MODEL_SPECIFIC_REGISTER_2ND) begin
                        dClass = `CLS_READ_MODEL_SPECIFIC_REGISTER;
                    end else if (byteIn == `OPC_READ_TIMESTAMP_COUNTER_2ND) begin
                        dClass = `CLS_READ_TIMESTAMP_COUNTER;
                    end
                end
            end
            S_MODRM: begin
                if (take) begin
                    next_state = S_FIRST;
                    dDone = 1'b1;
                    if (firstByte == `OPC_GROUP_FF && byteIn[5:3] == `REG_PUSH) begin
                        dClass = `CLS_PUSH_RM;
                    end else if (rotGroup && byteIn[5:3] == `REG_RCL) begin
                        dClass  = `CLS_RCL;
                        dClocks = rotByOne ? `CLK_RCL_ONE : `CLK_ROT_MULTI;
                    end else if (rotGroup && byteIn[5:3] == `REG_RCR) begin
                        dClass  = `CLS_RCR;
                        dClocks = rotByOne ? `CLK_RCR_ONE : `CLK_ROT_MULTI;
                        dOvCf   = rotByOne;
                    end
                end
            end
            S_REP: begin
                if (take) begin
                    next_state = S_SETUP;
                    dDone = 1'b1;
                    case (byteIn[7:1])
                        7'b0110110: begin
                            dClass  = `CLS_REP_INS;
                            dClocks = protectedMode ? `CLK_INS_PROT : `CLK_INS_REAL;
                            dIter   = `CLK_ITER_IO;
                        end
                        7'b1010110: begin
                            dClass  = `CLS_REP_LOAD_STRING;
                            dClocks = `CLK_LOAD_STRING;
                            dIter   = `CLK_ITER_MEM;
                        end
                        7'b1010010: begin
                            dClass  = `CLS_REP_MOVE_STRING;
                            dClocks = `CLK_MOVE_STRING;
                            dIter   = `CLK_ITER_MEM;
                        end
                        7'b0110111: begin
                            dClass  = `CLS_REP_OUTPUT_STRING;
                            dClocks = protectedMode ? `CLK_OUTPUT_STRING_PROT : `CLK_OUTPUT_STRING_REAL;
                            dIter   = `CLK_ITER_IO;
                        end
                        7'b1010101: begin
                            dClass  = `CLS_REP_STORE_STRING;
                            dClocks = `CLK_STORE_STRING;
                            dIter   = `CLK_ITER_MEM;
                        end
                        default: begin
                            next_state = S_FIRST;
                        end
                    endcase
                end
            end
            S_SETUP: begin
                if (cycleCount == `CLK_ONE) begin
                    next_state = (cntZero || !isRepeat) ? S_FIRST : S_ITER;
                end
            end
            S_ITER: begin
                if (iterCount == `CLK_ONE && lastIter) begin
                    next_state = S_FIRST;
                end
            end
            default: begin
                next_state = S_FIRST;
            end
        endcase
        if (state == S_FIRST && dDone) begin
            next_state = (dClocks == `CLK_ONE) ? S_FIRST : S_SETUP;
        end
        if ((state == S_ESC || state == S_MODRM) && dDone && dClocks != `CLK_ONE) begin
            next_state = S_SETUP;
        end
    end

    // the final iteration is the one that steps the count from one to zero
    wire lastIter  = (countRemaining == {{(COUNT_WIDTH-1){1'b0}}, 1'b1});
    wire loadCount = (state == S_REP) && take && (next_state == S_SETUP);
    wire stepCount = (state == S_ITER) && (iterCount == `CLK_ONE) && !cntZero;

    iteration_counter #(
        .WIDTH(COUNT_WIDTH)
    ) u_count (
        .clock    (clock),
        .nrst     (nrst),
        .load     (loadCount),
        .loadValue(countRegister),
        .step     (stepCount),
        .count    (countRemaining),
        .zero     (cntZero)
    );

    // ****************************************
    // registers and timing
    // ****************************************
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= S_FIRST;
            firstByte <= 8'h00;
            cycleCount <= 8'h00;
            iterCycles <= 8'h00;
            iterCount <= 8'h00;
            isRepeat <= 1'b0;
            instrValid <= 1'b0;
            instrClass <= `CLS_NONE;
            regField <= 3'h0;
            operandWidth <= 2'h0;
            signExtend <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            iterationStep <= 1'b0;
            writesOverflowCarry <= 1'b0;
        end else begin
            state <= next_state;
            instrValid <= 1'b0;
            done <= 1'b0;
            iterationStep <= 1'b0;
            if (state == S_FIRST && take) begin
                firstByte <= byteIn;
            end
            if (dDone) begin
                instrValid <= 1'b1;
                instrClass <= dClass;
                writesOverflowCarry <= dOvCf;
                isRepeat <= (state == S_REP);
                signExtend <= (dClass == `CLS_PUSH_IMM) && byteIn[1];
                regField <= (state == S_FIRST || state == S_ESC) ? byteIn[5:3]
                          : (state == S_MODRM ? byteIn[2:0] : 3'h0);
                if (state == S_FIRST) begin
                    regField <= byteIn[2:0];
                    if (dClass == `CLS_PUSH_SEG2) begin
                        regField <= {1'b0, byteIn[4:3]};
                    end
                end
                operandWidth <= widthOf((state == S_REP || state == S_MODRM)
                                        ? (state == S_REP ? byteIn[0] : firstByte[0])
                                        : 1'b1, operandSize32);
                iterCycles <= dIter;
                cycleCount <= dClocks;
                busy <= (dClocks != `CLK_ONE) || (state == S_REP);
                done <= (dClocks == `CLK_ONE) && (state != S_REP);
            end else if (state == S_SETUP) begin
                if (cycleCount == `CLK_ONE) begin
                    if (cntZero || !isRepeat) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        iterCount <= iterCycles;
                    end
                end else begin
                    cycleCount <= cycleCount - 8'h01;
                end
            end else if (state == S_ITER) begin
                cycleCount <= `CLK_ONE;
                if (iterCount == `CLK_ONE) begin
                    iterationStep <= 1'b1;
                    if (lastIter) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        iterCount <= iterCycles;
                    end
                end else begin
                    iterCount <= iterCount - 8'h01;
                end
            end
        end
    end
endmodule // instr_decoder

// ### instr_decoder_asserts.sv
// concurrent checks on the instruction decoder ports
`include "decode_consts.vh"
module instr_decoder_asserts #(
    parameter COUNT_WIDTH = 32
) (
    input wire logic                   clock,
    input wire logic                   nrst,
    input wire logic                   byteValid,
    input wire logic [7:0]             byteIn,
    input wire logic                   protectedMode,
    input wire logic                   operandSize32,
    input wire logic [COUNT_WIDTH-1:0] countRegister,
    input wire logic                   byteReady,
    input wire logic                   instrValid,
    input wire logic [4:0]             instrClass,
    input wire logic [2:0]             regField,
    input wire logic [1:0]             operandWidth,
    input wire logic                   signExtend,
    input wire logic                   busy,
    input wire logic                   done,
    input wire logic                   iterationStep,
    input wire logic                   writesOverflowCarry,
    input wire logic [COUNT_WIDTH-1:0] countRemaining
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // ****
    // properties
    // ****
    AST_SEG2_ONE: assert property (instrValid && instrClass == `CLS_PUSH_SEG2 |-> done)
        else $error("short segment push not done in one clock");
    AST_SEG3_ONE: assert property (instrValid && instrClass == `CLS_PUSH_SEG3 |-> done)
        else $error("escaped segment push not done in one clock");
    AST_PUSH_ALL_LEN: assert property (instrValid && instrClass == `CLS_PUSH_ALL
        |=> (!done)[*8] ##[1:3] done) else $error("push all length wrong");
    AST_FLAGS_LEN: assert property (instrValid && instrClass == `CLS_PUSH_FLAGS
        |-> ##[1:3] done) else $error("push flags length wrong");
    AST_BUSY_REFUSE: assert property (busy |-> !byteReady)
        else $error("byte accepted while busy");
    AST_OC_ONLY_RCR: assert property (writesOverflowCarry |-> instrClass == `CLS_RCR)
        else $error("overflow and carry written outside right rotate");
    AST_NO_FLAGS: assert property (instrValid && (instrClass == `CLS_PUSH_ALL
        || instrClass == `CLS_PUSH_FLAGS || instrClass == `CLS_READ_MODEL_SPECIFIC_REGISTER
        || instrClass == `CLS_READ_TIMESTAMP_COUNTER) |-> !writesOverflowCarry) else $error("flags touched");
    AST_IMM_SIGN: assert property (signExtend |-> instrClass == `CLS_PUSH_IMM)
        else $error("sign extend outside immediate push");
    AST_COUNT_DEC: assert property (busy && $past(busy) && countRemaining != $past(countRemaining)
        |-> countRemaining == $past(countRemaining) - 1) else $error("count not stepped by one");
endmodule // instr_decoder_asserts

bind instr_decoder instr_decoder_asserts #(.COUNT_WIDTH(COUNT_WIDTH)) instr_decoder_asserts_i (
    .clock(clock), .nrst(nrst), .byteValid(byteValid), .byteIn(byteIn),
    .protectedMode(protectedMode), .operandSize32(operandSize32), .countRegister(countRegister),
    .byteReady(byteReady), .instrValid(instrValid), .instrClass(instrClass),
    .regField(regField), .operandWidth(operandWidth), .signExtend(signExtend), .busy(busy),
    .done(done), .iterationStep(iterationStep), .writesOverflowCarry(writesOverflowCarry),
    .countRemaining(countRemaining));

// ### tb.sv
// self-checking bench for the instruction decoder
`include "decode_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0]  nb;
        logic [23:0] bytes;
        logic [4:0]  cls;
        logic [7:0]  base;
        logic [7:0]  iter;
        logic [2:0]  wid;
    } row_t;
    logic        clock, nrst, byteValid, protectedMode, operandSize32, gotOc;
    logic [7:0]  byteIn;
    logic [31:0] countRegister;
    logic [4:0]  gotCls;
    logic [1:0]  gotWid;
    wire         byteReady, instrValid, busy, done, iterationStep, writesOverflowCarry;
    wire         signExtend;
    wire  [4:0]  instrClass;
    wire  [2:0]  regField;
    wire  [1:0]  operandWidth;
    wire  [31:0] countRemaining;
    int          err_count, checks_done, steps, cyc, cnt;
    row_t        rows [19];

    instr_decoder instr_decoder_i (.clock(clock), .nrst(nrst), .byteValid(byteValid),
        .byteIn(byteIn), .protectedMode(protectedMode), .operandSize32(operandSize32),
        .countRegister(countRegister), .byteReady(byteReady), .instrValid(instrValid),
        .instrClass(instrClass), .regField(regField), .operandWidth(operandWidth),
        .signExtend(signExtend), .busy(busy), .done(done), .iterationStep(iterationStep),
        .writesOverflowCarry(writesOverflowCarry), .countRemaining(countRemaining));

    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // offered at a falling edge, held until a rising edge sees byteReady
    task automatic put(input logic [7:0] b);
        int k;
        byteIn = b;
        byteValid = 1'b1;
        for (k = 0; k < 100 && byteReady !== 1'b1; k++) @(negedge clock);
        @(negedge clock);
    endtask

    task automatic run(input row_t r);
        int k, t0, exp;
        steps = 0;
        t0 = 0;
        gotCls = 5'bx;
        countRegister = cnt;
        for (k = r.nb; k > 0; k--) put(r.bytes[8*k-1 -: 8]);
        byteValid = 1'b0;
        for (k = 0; k < 200; k++) begin
            if (instrValid === 1'b1) begin
                t0 = k;
                gotCls = instrClass;
                gotWid = operandWidth;
                gotOc = writesOverflowCarry;
            end
            if (iterationStep === 1'b1) steps++;
            if (done === 1'b1) break;
            @(negedge clock);
        end
        // a one-clock instruction ends in the same cycle that reports it
        cyc = (k == t0) ? 1 : k - t0;
        exp = r.base + r.iter * cnt;
        @(negedge clock);
        chk(gotCls, r.cls);
        if (r.base != 0) chk(cyc, exp);
        if (!r.wid[2]) chk(gotWid, r.wid[1:0]);
        chk(steps, r.iter != 0 ? cnt : 0);
        chk(gotOc, r.cls == `CLS_RCR && r.base == 8'd4);
    endtask

    task automatic rstchk();
        chk(byteReady, 1'b1);
        chk(instrValid, 1'b0);
        chk(busy, 1'b0);
        chk(countRemaining, 32'h0);
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        #300us;
        err_count++;
        wrap_up();
    end

    // ****
    // main sequence
    // ****
    initial begin
        rows = '{'{2, 24'hfff0, `CLS_PUSH_RM, 1, 0, 4}, '{1, 24'h53, `CLS_PUSH_REG, 1, 0, 4},
            '{1, 24'h1e, `CLS_PUSH_SEG2, 1, 0, 4}, '{2, 24'h0fa8, `CLS_PUSH_SEG3, 1, 0, 4},
            '{1, 24'h6a, `CLS_PUSH_IMM, 1, 0, 4}, '{1, 24'h60, `CLS_PUSH_ALL, 11, 0, 4},
            '{1, 24'h9c, `CLS_PUSH_FLAGS, 2, 0, 4}, '{2, 24'hd0d0, `CLS_RCL, 3, 0, 0},
            '{2, 24'hd3d0, `CLS_RCL, 8, 0, 2}, '{2, 24'hc1d0, `CLS_RCL, 8, 0, 2},
            '{2, 24'hd1d8, `CLS_RCR, 4, 0, 2}, '{2, 24'hd2d8, `CLS_RCR, 8, 0, 0},
            '{2, 24'h0f32, `CLS_READ_MODEL_SPECIFIC_REGISTER, 0, 0, 4}, '{2, 24'h0f31, `CLS_READ_TIMESTAMP_COUNTER, 0, 0, 4},
            '{2, 24'hf36c, `CLS_REP_INS, 17, 4, 0}, '{2, 24'hf3ad, `CLS_REP_LOAD_STRING, 9, 2, 2},
            '{2, 24'hf3a5, `CLS_REP_MOVE_STRING, 12, 2, 2}, '{2, 24'hf36f, `CLS_REP_OUTPUT_STRING, 24, 4, 2},
            '{2, 24'hf3aa, `CLS_REP_STORE_STRING, 9, 2, 0}};
        nrst = 1'b0;
        byteValid = 1'b0;
        byteIn = 8'h00;
        protectedMode = 1'b0;
        operandSize32 = 1'b1;
        cnt = 3;
        countRegister = 32'h3;
        repeat (5) @(negedge clock);
        rstchk();
        nrst = 1'b1;
        @(negedge clock);
        foreach (rows[i]) run(rows[i]);
        protectedMode = 1'b1;
        cnt = 0;
        run('{2, 24'hf36d, `CLS_REP_INS, 32, 4, 2});
        cnt = 2;
        run('{2, 24'hf36f, `CLS_REP_OUTPUT_STRING, 39, 4, 2});
        operandSize32 = 1'b0;
        run('{2, 24'hf3ab, `CLS_REP_STORE_STRING, 9, 2, 1});
        run('{1, 24'h90, `CLS_NONE, 0, 0, 4});
        // reset in mid-run must abandon the long push
        put(8'h60);
        byteValid = 1'b0;
        repeat (3) @(negedge clock);
        nrst = 1'b0;
        @(negedge clock);
        rstchk();
        nrst = 1'b1;
        @(negedge clock);
        wrap_up();
    end
endmodule // tb
